// [verif/cgt_host.sv]
// Host model: single write and read strobes on the register port.
// Assumes the clock of the trim block.
`timescale 1ns/100ps
module cgt_host (
   input  wire logic             clock,
   input  wire logic [7:0]       reg_rdata,
   output cgt_pkg::cgt_reg_req_t reg_req
);
   import cgt_pkg::*;
   // Port starts idle.
   initial reg_req = '0;
   // Write: low gain nibble always sent as zero; released lines show the inverse.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) #1 reg_req = {2'b10, a, (a == 8'h44 || a == 8'h49) ? (d & 8'hf0) : d};
      @(posedge clock) #1 reg_req = {2'b00, ~a, ~reg_req.wdata};
   endtask
   // Read: data is registered and valid after the taking edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock) #1 reg_req = {2'b01, a, ~reg_req.wdata};
      @(posedge clock) #1 reg_req = {2'b00, ~a, reg_req.wdata};
      d = reg_rdata;
   endtask
endmodule // cgt_host

// [verif/cgt_trim_chk.sv]
// Checker for the trim block, watching its ports only.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/100ps
module cgt_trim_chk (
   input wire logic                  clock,
   input wire logic                  sys_rst,
   input wire cgt_pkg::cgt_reg_req_t reg_req,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  mod_tick,
   input wire logic                  ch2_pdm_out,
   input wire cgt_pkg::cgt_sample_t  ch2_sample_in,
   input wire cgt_pkg::cgt_sample_t  ch2_sample_out,
   input wire cgt_pkg::cgt_sample_t  ch3_sample_in,
   input wire cgt_pkg::cgt_sample_t  ch3_sample_out
);
   import cgt_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Each sample leaves after its fixed pipeline depth, and only then.
   a_ch2_out_lat: assert property (ch2_sample_in.valid |=> ch2_sample_out.valid)
      else $error("ch2 out strobe missing");
   a_ch3_out_lat: assert property (ch3_sample_in.valid |-> ##2 ch3_sample_out.valid)
      else $error("ch3 out strobe missing");
   a_ch2_out_cause: assert property (ch2_sample_out.valid |-> $past(ch2_sample_in.valid))
      else $error("ch2 out strobe without input");
   a_ch3_out_cause: assert property (ch3_sample_out.valid |-> $past(ch3_sample_in.valid, 2))
      else $error("ch3 out strobe without input");
   // Scaling keeps silence silent.
   a_ch2_zero_in: assert property (ch2_sample_in.valid && ch2_sample_in.data == 0 |=> ch2_sample_out.data == 0)
      else $error("ch2 zero not kept");
   a_ch3_zero_in: assert property (ch3_sample_in.valid && ch3_sample_in.data == 0 |-> ##2 ch3_sample_out.data == 0)
      else $error("ch3 zero not kept");
   // Reserved gain bits always read back as zero.
   a_gain_rsv_zero: assert property (reg_req.rd && (reg_req.addr == 8'h44 || reg_req.addr == 8'h49)
      |=> reg_rdata[3:0] == 4'h0) else $error("gain reserved bits nonzero");
   // Delayed PDM bit moves only on a modulator tick.
   a_pdm_tick_hold: assert property (!mod_tick |=> $stable(ch2_pdm_out))
      else $error("pdm out moved without tick");
endmodule // cgt_trim_chk

bind cgt_trim cgt_trim_chk cgt_trim_chk_inst (.clock, .sys_rst, .reg_req, .reg_rdata, .mod_tick, .ch2_pdm_out,
   .ch2_sample_in, .ch2_sample_out, .ch3_sample_in, .ch3_sample_out);

// [verif/tb.sv]
// Testbench for the trim block: registers, sample scaling and PDM delay.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
module tb;
   import cgt_pkg::*;
   logic         clock = 0, sys_rst = 1, mod_tick = 0, ch2_pdm_in = 0, ch2_pdm_out;
   logic [7:0]   reg_rdata, rv;
   cgt_reg_req_t reg_req;
   cgt_sample_t  ch2_sample_in = '0, ch3_sample_in = '0, ch2_sample_out, ch3_sample_out;
   int           fail_count = 0, samples_checked = 0, cycles = 0;
   // Clock and a hang ceiling.
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         fail_count++;
         report_and_stop();
      end
   end
   cgt_host cgt_host_inst (.clock, .reg_rdata, .reg_req);
   cgt_trim cgt_trim_inst (.clock, .sys_rst, .reg_req, .reg_rdata, .mod_tick, .ch2_pdm_in, .ch2_pdm_out,
      .ch2_sample_in, .ch2_sample_out, .ch3_sample_in, .ch3_sample_out);
   // Compare and count.
   task automatic check(input string n, input logic [24:0] seen, input logic [24:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      cgt_host_inst.rd(a, rv);
      check("register", {17'h0, rv}, {17'h0, exp});
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic t_reset();
      rchk(8'h44, 8'h80);
      rchk(8'h49, 8'h80);
      rchk(8'h45, 8'h00);
      rchk(8'h48, 8'hc9);
   endtask
   task automatic t_regs();
      cgt_host_inst.wr(8'h44, 8'hf0);
      rchk(8'h44, 8'hf0);
      cgt_host_inst.wr(8'h49, 8'h30);
      rchk(8'h49, 8'h30);
      cgt_host_inst.wr(8'h45, 8'hff);
      rchk(8'h45, 8'hff);
   endtask
   // One sample on both channels after setting trims and volume.
   task automatic t_samp(input logic [7:0] g, input logic [7:0] v, input logic [23:0] d, input logic [23:0] e2,
                         input logic [23:0] e3);
      cgt_host_inst.wr(8'h44, g);
      cgt_host_inst.wr(8'h49, g);
      cgt_host_inst.wr(8'h48, v);
      @(posedge clock) #1;
      ch2_sample_in = {1'b1, d};
      ch3_sample_in = {1'b1, d};
      @(posedge clock) #1;
      ch2_sample_in = {1'b0, ~d};
      ch3_sample_in = {1'b0, ~d};
      check("ch2 out", ch2_sample_out, {1'b1, e2});
      @(posedge clock) #1;
      check("ch3 out", ch3_sample_out, {1'b1, e3});
   endtask
   // Flush the delay line with zeros, then time a rising PDM bit.
   task automatic t_pdm(input int n);
      cgt_host_inst.wr(8'h45, n[7:0]);
      ch2_pdm_in = 0;
      mod_tick = 1;
      repeat (300) @(posedge clock);
      #1 ch2_pdm_in = 1;
      repeat (n + 2) @(posedge clock);
      #1 check("pdm early", {24'h0, ch2_pdm_out}, 25'h0);
      @(posedge clock) #1;
      check("pdm due", {24'h0, ch2_pdm_out}, 25'h1);
      mod_tick = 0;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #1 sys_rst = 0;
      t_reset();
      t_regs();
      t_samp(8'h80, 8'hc9, 24'h100000, 24'h100000, 24'h100000);
      t_samp(8'h80, 8'h00, 24'h100000, 24'h100000, 24'h000000);
      t_samp(8'h80, 8'hd5, 24'h100000, 24'h100000, 24'h200000);
      t_samp(8'h80, 8'hc9, 24'h000000, 24'h000000, 24'h000000);
      t_samp(8'h00, 8'hc9, 24'h100000, 24'h0e97c0, 24'h0e97c0);
      t_samp(8'hf0, 8'hd5, 24'h100000, 24'h1157c0, 24'h22af80);
      t_pdm(0);
      t_pdm(255);
      report_and_stop();
   end
endmodule // tb

// [verilog/cgt_pkg.sv]
// Package for the per-channel gain, phase and volume trim block.
// Assumes a single 40 MHz clock and an 8-bit register port in the same domain.
package cgt_pkg;

   // Register offsets.
   localparam logic [7:0] CH2_GAIN_TRIM_CFG_OFS   = 8'h44;
   localparam logic [7:0] CH2_PHASE_DELAY_CFG_OFS = 8'h45;
   localparam logic [7:0] CH3_VOLUME_CFG_OFS      = 8'h48;
   localparam logic [7:0] CH3_GAIN_TRIM_CFG_OFS   = 8'h49;

   // Values after reset.
   localparam logic [7:0] GAIN_TRIM_RST   = 8'h80;
   localparam logic [7:0] PHASE_DELAY_RST = 8'h00;
   localparam logic [7:0] VOLUME_RST      = 8'hc9;

   // Field layout: gain code in the high nibble, low nibble reserved.
   localparam int         GAIN_CODE_LSB  = 4;
   localparam logic [7:0] GAIN_WR_MASK   = 8'hf0;

   // Volume code of 0 dB and the offset that makes the index non-negative.
   localparam logic [8:0] VOL_UNITY      = 9'h0c9;
   localparam logic [8:0] VOL_BIAS       = 9'h0cc;
   localparam logic [4:0] VOL_OCT_UNITY  = 5'h11;
   localparam int         COEF_FRAC      = 14;

   // Sample width and phase history length in modulator cycles.
   localparam int SAMPLE_W   = 24;
   localparam int PHASE_MAX  = 255;

   // One decimated sample with its strobe.
   typedef struct packed {
      logic                valid;
      logic [SAMPLE_W-1:0] data;
   } cgt_sample_t;

   // Register port request.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cgt_reg_req_t;

   // Linear gain for a 4-bit trim code, 0.1 dB per step, Q2.14.
   function automatic logic [15:0] gain_coef(input logic [3:0] code);
      logic [15:0] c;
      c = 16'h4000;
      case (code)
         4'h0: c = 16'h3a5f;
         4'h1: c = 16'h3b0b;
         4'h2: c = 16'h3bba;
         4'h3: c = 16'h3c6c;
         4'h4: c = 16'h3d1e;
         4'h5: c = 16'h3dd4;
         4'h6: c = 16'h3e8b;
         4'h7: c = 16'h3f44;
         4'h8: c = 16'h4000;
         4'h9: c = 16'h40be;
         4'ha: c = 16'h417e;
         4'hb: c = 16'h4240;
         4'hc: c = 16'h4304;
         4'hd: c = 16'h43cb;
         4'he: c = 16'h4494;
         4'hf: c = 16'h455f;
         default: c = 16'h4000;
      endcase
      return c;
   endfunction

   // Linear gain for 0 to 11 half-dB steps within one octave, Q2.14.
   function automatic logic [15:0] vol_fine_coef(input logic [3:0] idx);
      logic [15:0] c;
      c = 16'h4000;
      case (idx)
         4'h0: c = 16'h4000;
         4'h1: c = 16'h43cb;
         4'h2: c = 16'h47cf;
         4'h3: c = 16'h4c11;
         4'h4: c = 16'h5092;
         4'h5: c = 16'h5559;
         4'h6: c = 16'h5a67;
         4'h7: c = 16'h5fc2;
         4'h8: c = 16'h656f;
         4'h9: c = 16'h6b72;
         4'ha: c = 16'h71cf;
         4'hb: c = 16'h788e;
         default: c = 16'h4000;
      endcase
      return c;
   endfunction

endpackage

// [verilog/cgt_trim.sv]
// Per-channel trim: gain trim and phase delay for channel 2, gain trim and volume for channel 3.
// Assumes register port, sample streams and modulator tick are on clock; the PDM pin is asynchronous.
// Overview of operation
// - Gain trim code 0 gives -0.8 dB, each step adds 0.1 dB, code 8 is unity and code 15 gives +0.7 dB.
// - Each gain trim register resets to 0x80, so the code is 8 and the reserved nibble is zero.
// - The phase delay code delays the channel by that many modulator cycles, 1 up to 255.
// - Phase delay code zero adds no delay, and the phase register resets to zero.
// - Volume code zero mutes the channel's output samples completely.
// - Nonzero volume codes scale in 0.5 dB steps, code 1 is -100 dB, 201 is 0 dB and 255 is +27 dB.
// - Each volume register resets to 0xC9, which is 0 dB.
// - The reserved low nibble of a gain trim register reads zero and only zero is stored there.
`timescale 1ns/100ps
module cgt_trim (
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire cgt_pkg::cgt_reg_req_t  reg_req,
   output logic [7:0]                  reg_rdata,
   input  wire logic                   mod_tick,
   input  wire logic                   ch2_pdm_in,
   output logic                        ch2_pdm_out,
   input  wire cgt_pkg::cgt_sample_t   ch2_sample_in,
   output cgt_pkg::cgt_sample_t        ch2_sample_out,
   input  wire cgt_pkg::cgt_sample_t   ch3_sample_in,
   output cgt_pkg::cgt_sample_t        ch3_sample_out
);
   import cgt_pkg::*;

   typedef struct packed {
      logic [7:0]           ch2_gain_trim_cfg;
      logic [7:0]           ch2_phase_delay_cfg;
      logic [7:0]           ch3_volume_cfg;
      logic [7:0]           ch3_gain_trim_cfg;
      logic [7:0]           rdata;
      logic [1:0]           pdm_sync;
      logic [PHASE_MAX-1:0] pdm_hist;
      logic                 pdm_out;
      cgt_sample_t          ch2_out;
      cgt_sample_t          ch3_mid;
      cgt_sample_t          ch3_out;
   } cgt_state_t;

   localparam cgt_state_t STATE_RST = '{
      ch2_gain_trim_cfg:   GAIN_TRIM_RST,
      ch2_phase_delay_cfg: PHASE_DELAY_RST,
      ch3_volume_cfg:      VOLUME_RST,
      ch3_gain_trim_cfg:   GAIN_TRIM_RST,
      rdata:               8'h00,
      pdm_sync:            2'h0,
      pdm_hist:            '0,
      pdm_out:             1'b0,
      ch2_out:             '0,
      ch3_mid:             '0,
      ch3_out:             '0
   };

   cgt_state_t state;
   cgt_state_t next_state;

   // Clamps a wide signed value to the sample range.
   function automatic logic [SAMPLE_W-1:0] saturate(input logic signed [63:0] v);
      logic signed [63:0] hi;
      logic signed [63:0] lo;
      hi = 64'sh0000_0000_007f_ffff;
      lo = -64'sh0000_0000_0080_0000;
      if (v > hi) begin
         return hi[SAMPLE_W-1:0];
      end else if (v < lo) begin
         return lo[SAMPLE_W-1:0];
      end
      return v[SAMPLE_W-1:0];
   endfunction

   // Applies the 4-bit gain trim to one sample.
   function automatic logic [SAMPLE_W-1:0] apply_gain(input logic [SAMPLE_W-1:0] s,
                                                      input logic [7:0] cfg);
      logic signed [63:0] p;
      p = 64'($signed(s)) * 64'($signed({1'b0, gain_coef(cfg[7:GAIN_CODE_LSB])}));
      return saturate(p >>> COEF_FRAC);
   endfunction

   // Applies the volume code: fine half-dB step from a table, coarse octave by shifting.
   function automatic logic [SAMPLE_W-1:0] apply_volume(input logic [SAMPLE_W-1:0] s,
                                                        input logic [7:0] vol);
      logic [8:0]         idx;
      logic [4:0]         oct;
      logic [3:0]         fine;
      logic signed [63:0] p;
      idx  = 9'({1'b0, vol}) + VOL_BIAS - VOL_UNITY;
      oct  = 5'(idx / 9'd12);
      fine = 4'(idx % 9'd12);
      p    = 64'($signed(s)) * 64'($signed({1'b0, vol_fine_coef(fine)}));
      p    = (p <<< oct) >>> (COEF_FRAC + 32'(VOL_OCT_UNITY));
      if (vol == 8'h00) begin
         return '0;
      end
      return saturate(p);
   endfunction

   // Next state: register port, phase delay line and sample scaling.
   always_comb begin
      next_state = state;
      // Register writes; gain trim stores only the code nibble.
      if (reg_req.wr) begin
         if (reg_req.addr == CH2_GAIN_TRIM_CFG_OFS) begin
            next_state.ch2_gain_trim_cfg = reg_req.wdata & GAIN_WR_MASK;
         end else if (reg_req.addr == CH2_PHASE_DELAY_CFG_OFS) begin
            next_state.ch2_phase_delay_cfg = reg_req.wdata;
         end else if (reg_req.addr == CH3_VOLUME_CFG_OFS) begin
            next_state.ch3_volume_cfg = reg_req.wdata;
         end else if (reg_req.addr == CH3_GAIN_TRIM_CFG_OFS) begin
            next_state.ch3_gain_trim_cfg = reg_req.wdata & GAIN_WR_MASK;
         end
      end
      // Register reads; unmapped offsets read zero.
      if (reg_req.rd) begin
         if (reg_req.addr == CH2_GAIN_TRIM_CFG_OFS) begin
            next_state.rdata = state.ch2_gain_trim_cfg & GAIN_WR_MASK;
         end else if (reg_req.addr == CH2_PHASE_DELAY_CFG_OFS) begin
            next_state.rdata = state.ch2_phase_delay_cfg;
         end else if (reg_req.addr == CH3_VOLUME_CFG_OFS) begin
            next_state.rdata = state.ch3_volume_cfg;
         end else if (reg_req.addr == CH3_GAIN_TRIM_CFG_OFS) begin
            next_state.rdata = state.ch3_gain_trim_cfg & GAIN_WR_MASK;
         end else begin
            next_state.rdata = 8'h00;
         end
      end
      // Pin synchroniser; only the second stage feeds the delay line.
      next_state.pdm_sync = {state.pdm_sync[0], ch2_pdm_in};
      // Delay line advances once per modulator cycle and taps the selected age.
      if (mod_tick) begin
         next_state.pdm_hist = {state.pdm_hist[PHASE_MAX-2:0], state.pdm_sync[1]};
         if (state.ch2_phase_delay_cfg == 8'h00) begin
            next_state.pdm_out = state.pdm_sync[1];
         end else begin
            next_state.pdm_out = state.pdm_hist[state.ch2_phase_delay_cfg - 8'h01];
         end
      end
      // Channel 2 gain trim, one cycle of latency.
      next_state.ch2_out.valid = ch2_sample_in.valid;
      if (ch2_sample_in.valid) begin
         next_state.ch2_out.data = apply_gain(ch2_sample_in.data, state.ch2_gain_trim_cfg);
      end
      // Channel 3 gain trim then volume, cascaded so the dB values add.
      next_state.ch3_mid.valid = ch3_sample_in.valid;
      if (ch3_sample_in.valid) begin
         next_state.ch3_mid.data = apply_gain(ch3_sample_in.data, state.ch3_gain_trim_cfg);
      end
      next_state.ch3_out.valid = state.ch3_mid.valid;
      if (state.ch3_mid.valid) begin
         next_state.ch3_out.data = apply_volume(state.ch3_mid.data, state.ch3_volume_cfg);
      end
   end

   // State register with reset values for every setting.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= STATE_RST;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register.
   assign reg_rdata      = state.rdata;
   assign ch2_pdm_out    = state.pdm_out;
   assign ch2_sample_out = state.ch2_out;
   assign ch3_sample_out = state.ch3_out;

endmodule // cgt_trim
